//--- rtl/analog_output_state_control.v
// Output state control for one analog output channel with an APB register slave
//
// Notes on behaviour
// R1: Sample inputs every sample period milliseconds
// R2: Input range is upper nibble of byte
// R3: Fault in program mode obeys program-to-fault enable
// R4: Hold output until command within 0.1%
// R5: Hold on start, program-to-run, fault recovery
// R6: Fault: hold last or drive fault value
// R7: Program entry: hold last or program value
// R8: Ramp toward program value at limited rate
// R9: Ramp toward fault value at limited rate
// R10: Fault value is signed count, when selected
// R11: Program value is signed count, when selected
// R12: Ramp rate is percent full scale per second
// R13: Report in-hold flag while waiting for match
// R14: Without ramping, step straight to target
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "aostate_map.vh"

module analog_output_state_control #(
  parameter        CYC_PER_MS = `CYC_PER_MS,
  parameter        FULL_SCALE = `FULL_SCALE_CNT,
  parameter [33:0] RAMP_DIV   = `RAMP_DIV
) (
  // Clock, reset, enable
  input  wire        mclk,
  input  wire        rst,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Connection state from the controller link
  input  wire        comm_fault,
  input  wire        program_mode,
  // Output and input-side controls
  output reg  [15:0] out_value,
  output reg         output_in_hold_flag,
  output reg         sample_strobe,
  output reg  [3:0]  input_range,
  output reg  [3:0]  notch_select
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_INIT  = 5'h01;
  localparam [4:0] ST_RUN   = 5'h02;
  localparam [4:0] ST_HOLD  = 5'h04;
  localparam [4:0] ST_FAULT = 5'h08;
  localparam [4:0] ST_PROG  = 5'h10;

  localparam integer MATCH_TOL_I = FULL_SCALE / `MATCH_PER_MILLE;
  localparam [16:0]  MATCH_TOL   = MATCH_TOL_I[16:0];
  localparam [31:0] MS_LAST   = CYC_PER_MS - 1;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        program_to_fault_enable_r;
  reg [4:0]  output_channel_config_byte_r;
  reg [15:0] fault_output_value_r;
  reg [15:0] program_output_value_r;
  reg [15:0] max_ramp_rate_r;
  reg [15:0] sample_period_ms_r;
  reg [7:0]  range_and_notch_select_r;
  reg [15:0] out_data_r;
  reg [4:0]  state_r;
  reg [4:0]  state_nxt;
  reg [33:0] ramp_acc_r;
  reg [31:0] ms_cnt_r;
  reg [15:0] period_cnt_r;

  wire hold_until_matched     = output_channel_config_byte_r[`BIT_HOLD_MATCH];
  wire fault_action_select    = output_channel_config_byte_r[`BIT_FAULT_ACT];
  wire program_action_select  = output_channel_config_byte_r[`BIT_PROG_ACT];
  wire ramp_to_program_enable = output_channel_config_byte_r[`BIT_RAMP_PROG];
  wire ramp_to_fault_enable   = output_channel_config_byte_r[`BIT_RAMP_FAULT];

  // Absolute difference of two signed counts
  function [16:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] d;
    begin
      d = {a[15], a} - {b[15], b};
      abs_diff = d[16] ? (~d + 17'h00001) : d;
    end
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state keeps pready and prdata straight from flip-flops
  wire acc_phase = psel & penable & ~pready;
  wire wr_en     = acc_phase & pwrite;
  wire mapped    = (paddr[1:0] == 2'h0) && (paddr <= `OFS_STATUS);
  wire ramping   = (state_r == ST_FAULT && fault_action_select && ramp_to_fault_enable) ||
                   (state_r == ST_PROG && program_action_select && ramp_to_program_enable);

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `OFS_MODULE_CFG:  rd_mux[0] = program_to_fault_enable_r;
      `OFS_CHAN_CFG:    rd_mux[4:0] = output_channel_config_byte_r;
      `OFS_FAULT_VAL:   rd_mux[15:0] = fault_output_value_r;
      `OFS_PROG_VAL:    rd_mux[15:0] = program_output_value_r;
      `OFS_RAMP_RATE:   rd_mux[15:0] = max_ramp_rate_r;
      `OFS_SAMPLE_MS:   rd_mux[15:0] = sample_period_ms_r;
      `OFS_RANGE_NOTCH: rd_mux[7:0] = range_and_notch_select_r;
      `OFS_OUT_DATA:    rd_mux[15:0] = out_data_r;
      `OFS_OUT_NOW:     rd_mux[15:0] = out_value;
      `OFS_STATUS: begin
        rd_mux[`BIT_ST_IN_HOLD] = output_in_hold_flag;
        rd_mux[`BIT_ST_RAMPING] = ramping;
      end
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Bus response kept apart from the register file so every answer comes from a flop
  always @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= acc_phase;
      pslverr <= acc_phase & ~mapped;
      prdata  <= (acc_phase & ~pwrite & mapped) ? rd_mux : 32'h00000000;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      program_to_fault_enable_r    <= `RST_MODULE_CFG;
      output_channel_config_byte_r <= `RST_CHAN_CFG;
      fault_output_value_r         <= `RST_VALUE;
      program_output_value_r       <= `RST_VALUE;
      max_ramp_rate_r              <= `RST_RAMP_RATE;
      sample_period_ms_r           <= `RST_SAMPLE_MS;
      range_and_notch_select_r     <= `RST_RANGE_NOTCH;
      out_data_r                   <= `RST_VALUE;
    end else if (ce) begin
      if (wr_en) begin
        case (paddr)
          `OFS_MODULE_CFG:  program_to_fault_enable_r <= pwdata[`BIT_PROG_TO_FAULT];
          `OFS_CHAN_CFG:    output_channel_config_byte_r <= pwdata[4:0];
          `OFS_FAULT_VAL:   fault_output_value_r <= pwdata[15:0];
          `OFS_PROG_VAL:    program_output_value_r <= pwdata[15:0];
          `OFS_RAMP_RATE:   max_ramp_rate_r <= pwdata[15:0];
          `OFS_SAMPLE_MS:   sample_period_ms_r <= pwdata[15:0];
          `OFS_RANGE_NOTCH: range_and_notch_select_r <= pwdata[7:0];
          `OFS_OUT_DATA:    out_data_r <= pwdata[15:0];
          default:          out_data_r <= out_data_r;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Input-side settings
  // ----------------------------------------
  // A period of zero is treated as one millisecond rather than stalling sampling
  always @(posedge mclk) begin
    if (rst) begin
      ms_cnt_r      <= 32'h00000000;
      period_cnt_r  <= 16'h0000;
      sample_strobe <= 1'b0;
      input_range   <= 4'h0;
      notch_select  <= 4'h0;
    end else if (ce) begin
      // R2: range nibble split
      input_range   <= range_and_notch_select_r[`RANGE_HI:`RANGE_LO];
      notch_select  <= range_and_notch_select_r[`NOTCH_HI:`NOTCH_LO];
      sample_strobe <= 1'b0;
      if (ms_cnt_r >= MS_LAST) begin
        ms_cnt_r <= 32'h00000000;
        // R1: millisecond sample period
        if (period_cnt_r + 16'h0001 >= sample_period_ms_r) begin
          period_cnt_r  <= 16'h0000;
          sample_strobe <= 1'b1;
        end else begin
          period_cnt_r <= period_cnt_r + 16'h0001;
        end
      end else begin
        ms_cnt_r <= ms_cnt_r + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // Output state machine
  // ----------------------------------------
  wire matched = abs_diff(out_data_r, out_value) <= MATCH_TOL;

  // A fault or program request outranks every other transition
  reg        link_event;
  reg [4:0]  link_state;
  always @* begin
    link_event = comm_fault | program_mode;
    link_state = ST_FAULT;
    // R3: program mode fault choice
    if (!comm_fault) begin
      link_state = ST_PROG;
    end else if (program_mode && !program_to_fault_enable_r && state_r != ST_FAULT) begin
      link_state = ST_PROG;
    end
  end

  always @* begin
    case (state_r)
      ST_INIT, ST_FAULT, ST_PROG: begin
        // R5: start, return to run, recovery
        if (link_event)
          state_nxt = link_state;
        else if (hold_until_matched)
          state_nxt = ST_HOLD;
        else
          state_nxt = ST_RUN;
      end
      ST_HOLD: begin
        // R4: release on close command
        if (link_event)
          state_nxt = link_state;
        else if (matched)
          state_nxt = ST_RUN;
        else
          state_nxt = ST_HOLD;
      end
      ST_RUN: begin
        // Commands pass straight through until the link changes
        if (link_event)
          state_nxt = link_state;
        else
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  // ----------------------------------------
  // Output value
  // ----------------------------------------
  reg [15:0] target;
  reg        use_ramp;
  always @* begin
    target   = out_value;
    use_ramp = 1'b0;
    case (state_r)
      ST_RUN: target = out_data_r;
      ST_FAULT: begin
        // R6: hold or fault value
        // R10: signed fault count
        if (fault_action_select)
          target = fault_output_value_r;
        // R9: ramp toward fault
        use_ramp = ramp_to_fault_enable;
      end
      ST_PROG: begin
        // R7: hold or program value
        // R11: signed program count
        if (program_action_select)
          target = program_output_value_r;
        // R8: ramp toward program
        use_ramp = ramp_to_program_enable;
      end
      default: target = out_value;
    endcase
  end

  // Accumulates rate x full scale per clock; one count moves per RAMP_DIV units
  wire [33:0] acc_sum = ramp_acc_r + ({18'h00000, max_ramp_rate_r} * FULL_SCALE[15:0]);
  wire        tgt_up  = $signed(target) > $signed(out_value);

  always @(posedge mclk) begin
    if (rst) begin
      state_r             <= ST_INIT;
      out_value           <= `RST_VALUE;
      output_in_hold_flag <= 1'b0;
      ramp_acc_r          <= 34'h000000000;
    end else if (ce) begin
      state_r <= state_nxt;
      // R13: in-hold status
      output_in_hold_flag <= (state_nxt == ST_HOLD);
      if (target == out_value || !use_ramp) begin
        ramp_acc_r <= 34'h000000000;
        // R14: direct step
        out_value  <= target;
      end else if (acc_sum >= RAMP_DIV) begin
        // R12: percent full scale per second
        ramp_acc_r <= acc_sum - RAMP_DIV;
        out_value  <= tgt_up ? out_value + 16'h0001 : out_value - 16'h0001;
      end else begin
        ramp_acc_r <= acc_sum;
      end
    end
  end

endmodule

//--- common/aostate_map.vh
// Register map, field positions, reset values and timing for the output state control block
`ifndef AOSTATE_MAP_VH
`define AOSTATE_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODULE_CFG   8'h00
`define OFS_CHAN_CFG     8'h04
`define OFS_FAULT_VAL    8'h08
`define OFS_PROG_VAL     8'h0c
`define OFS_RAMP_RATE    8'h10
`define OFS_SAMPLE_MS    8'h14
`define OFS_RANGE_NOTCH  8'h18
`define OFS_OUT_DATA     8'h1c
`define OFS_OUT_NOW      8'h20
`define OFS_STATUS       8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_PROG_TO_FAULT 0
`define BIT_HOLD_MATCH    0
`define BIT_FAULT_ACT     1
`define BIT_PROG_ACT      2
`define BIT_RAMP_PROG     3
`define BIT_RAMP_FAULT    4
`define BIT_ST_IN_HOLD    0
`define BIT_ST_RAMPING    1
`define RANGE_HI          7
`define RANGE_LO          4
`define NOTCH_HI          3
`define NOTCH_LO          0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MODULE_CFG   1'h0
`define RST_CHAN_CFG     5'h00
`define RST_VALUE        16'h0000
`define RST_RAMP_RATE    16'h0000
`define RST_SAMPLE_MS    16'h0001
`define RST_RANGE_NOTCH  8'h00

// ----------------------------------------
// Timing and scaling
// ----------------------------------------
`define CLK_HZ           34'd50000000
`define CLK_PERIOD_NS    20
`define MS_NS            1000000
`define CYC_PER_MS       (`MS_NS / `CLK_PERIOD_NS)
`define PCT_FULL         34'd100
`define RAMP_DIV         (`PCT_FULL * `CLK_HZ)
`define MATCH_PER_MILLE  1000
`define FULL_SCALE_CNT   32767

`endif

//--- tb/aostate_checker_properties.sv
// Assertion checker for the output state control block
`timescale 1ns/1ps
module aostate_checker (
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  input wire        ce,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Link and outputs
  input wire        comm_fault,
  input wire        program_mode,
  input wire [15:0] out_value,
  input wire        output_in_hold_flag,
  input wire        sample_strobe,
  input wire [3:0]  input_range,
  input wire [3:0]  notch_select
);
  wire      req = psel && penable && !pready && ce;
  reg [7:0] range_q;
  // Keeps the last byte written, so the check survives a later bus transfer
  always @(posedge mclk) begin
    if (pready && pwrite && paddr == 8'h18)
      range_q <= pwdata[7:0];
  end
  property p_apb_wait;
    @(posedge mclk) disable iff (rst) req |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_apb_pulse;
    @(posedge mclk) disable iff (rst) pready && ce |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
  property p_unmapped;
    @(posedge mclk) disable iff (rst) req && paddr > 8'h24 |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_range;
    @(posedge mclk) disable iff (rst) pready && pwrite && paddr == 8'h18 && !pslverr
      |=> ##[0:1] {input_range, notch_select} == range_q;
  endproperty
  a_range: assert property (p_range) else $error("range or notch wrong");
  property p_hold_frozen;
    @(posedge mclk) disable iff (rst) output_in_hold_flag && $past(output_in_hold_flag) |-> $stable(out_value);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("output moved in hold");
  property p_hold_entry;
    @(posedge mclk) disable iff (rst) $rose(output_in_hold_flag) |-> ($past(comm_fault, 2) && !$past(comm_fault))
      || ($past(program_mode, 2) && !$past(program_mode)) || $past(rst, 2) || $past(rst, 3);
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("hold without cause");
  property p_strobe_gap;
    @(posedge mclk) disable iff (rst) sample_strobe && ce |=> !sample_strobe [*8];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("sample strobes too close");
  property p_reset_out;
    @(posedge mclk) disable iff (rst) $fell(rst) |-> out_value == 16'h0000 && !pready && !output_in_hold_flag;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
endmodule
bind analog_output_state_control aostate_checker aostate_checker_i (.mclk(mclk), .rst(rst), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .comm_fault(comm_fault), .program_mode(program_mode),
  .out_value(out_value), .output_in_hold_flag(output_in_hold_flag), .sample_strobe(sample_strobe),
  .input_range(input_range), .notch_select(notch_select));

//--- tb/host_link_model.sv
// Host controller model driving the connection state toward the block
`timescale 1ns/1ps
module host_link_model (
  // Clock
  input  wire       mclk,
  // Requested state: bit1 fault, bit0 program
  input  wire [1:0] link_req,
  // Connection state
  output reg        comm_fault,
  output reg        program_mode
);
  initial begin
    comm_fault = 1'b0;
    program_mode = 1'b0;
  end
  // State changes only at edges, as a synchronous link would deliver them
  always @(posedge mclk) begin
    comm_fault   <= link_req[1];
    program_mode <= link_req[0];
  end
endmodule

//--- tb/analog_output_state_control_test.sv
// Self-checking bench for the output state control block
`timescale 1ns/1ps
module analog_output_state_control_test;
  reg         mclk;
  reg         rst;
  reg         ce;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg  [1:0]  link_req;
  reg  [31:0] rd;
  reg         err_seen;
  wire        pready;
  wire        pslverr;
  wire        comm_fault;
  wire        program_mode;
  wire        output_in_hold_flag;
  wire        sample_strobe;
  wire [31:0] prdata;
  wire [15:0] out_value;
  wire [3:0]  input_range;
  wire [3:0]  notch_select;
  integer     failures;
  integer     checks_done;
  integer     n;
  // Short counts keep the run brief; expectations below follow these values
  analog_output_state_control #(.CYC_PER_MS(10), .RAMP_DIV(34'd100000)) analog_output_state_control_i (
    .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .comm_fault(comm_fault),
    .program_mode(program_mode), .out_value(out_value), .output_in_hold_flag(output_in_hold_flag),
    .sample_strobe(sample_strobe), .input_range(input_range), .notch_select(notch_select));
  host_link_model host_link_model_i (.mclk(mclk), .link_req(link_req), .comm_fault(comm_fault),
    .program_mode(program_mode));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task report_and_stop;
    begin
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [8*10:1] what, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge mclk);
  endtask
  // One APB transfer, then two idle edges so registered outputs settle
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (pready !== 1'b1) begin
        failures = failures + 1;
        report_and_stop;
      end
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(2);
    end
  endtask
  initial begin
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    link_req = 2'b00;
    cyc(3);
    rst <= 1'b0;
    apb(0, 8'h04, 0); chk("chan_cfg", 32'h0, rd);
    apb(0, 8'h14, 0); chk("sample_ms", 32'h1, rd);
    apb(0, 8'h28, 0); chk("unmapped", 32'h1, {rd[30:0], err_seen});
    apb(1, 8'h18, 32'ha5); chk("range", 32'ha5, {input_range, notch_select});
    apb(1, 8'h14, 32'h3); cyc(40); n = 0;
    repeat (300) begin
      @(posedge mclk);
      if (sample_strobe === 1'b1) n = n + 1;
    end
    chk("strobes", 32'd10, n);
    apb(1, 8'h08, 32'hf000); apb(1, 8'h04, 32'h03); apb(1, 8'h1c, 32'h0100);
    chk("run out", 32'h0100, out_value);
    link_req <= 2'b10; cyc(4); chk("fault out", 32'hf000, out_value);
    link_req <= 2'b00; cyc(4); chk("hold flag", 32'h1, output_in_hold_flag);
    apb(1, 8'h1c, 32'h0200); chk("held out", 32'hf000, out_value);
    apb(0, 8'h24, 0); chk("status", 32'h1, rd);
    apb(0, 8'h20, 0); chk("out now", 32'hf000, rd);
    apb(1, 8'h1c, 32'hf010); cyc(3); chk("matched", 32'h0f010, {output_in_hold_flag, out_value});
    link_req <= 2'b01; cyc(4); chk("prog hold", 32'hf010, out_value);
    link_req <= 2'b11; cyc(4); chk("prog flt", 32'hf010, out_value);
    link_req <= 2'b01; apb(1, 8'h00, 32'h1);
    link_req <= 2'b11; cyc(4); chk("to fault", 32'hf000, out_value);
    apb(1, 8'h04, 32'h0c); apb(1, 8'h0c, 32'h40); apb(1, 8'h10, 32'd1);
    link_req <= 2'b00; apb(1, 8'h1c, 32'h0); cyc(4);
    // Rate 1 gives 32767 of 100000 units per clock: 31 counts after 97 ramp clocks
    link_req <= 2'b01; cyc(100); chk("ramp up", 32'h1, out_value >= 16'd28 && out_value <= 16'd32);
    cyc(150); chk("prog val", 32'h40, out_value);
    apb(1, 8'h04, 32'h12); apb(1, 8'h08, 32'hfff0);
    link_req <= 2'b11; cyc(100); chk("ramp dn", 32'h1, out_value >= 16'd32 && out_value <= 16'd36);
    // One more step lands at the edge that lowers the enable, then all state freezes
    ce <= 1'b0; cyc(11); chk("frozen", 32'd32, out_value);
    ce <= 1'b1; cyc(200); chk("fault val", 32'hfff0, out_value);
    report_and_stop;
  end
endmodule
